/* File: pkg/acs_pkg.sv */
package acs_pkg;
    // register byte addresses (word aligned on the bus)
    localparam logic [11:0] GROUP_SEL_ADDR = 12'h000;
    localparam logic [11:0] ZERO_SEL_ADDR  = 12'h004;
    localparam logic [11:0] MODE_ADDR      = 12'h008;
    localparam logic [11:0] STATUS_ADDR    = 12'h00c;
    // group select fields
    localparam int GRP_POS_A_BIT = 0;
    localparam int GRP_NEG_A_LSB = 1;
    localparam int GRP_POS_B_BIT = 8;
    localparam int GRP_NEG_B_LSB = 9;
    // channel zero select fields
    localparam int ZERO_POS_A_LSB = 0;
    localparam int ZERO_NEG_A_BIT = 7;
    localparam int ZERO_POS_B_LSB = 8;
    localparam int ZERO_NEG_B_BIT = 15;
    // writable bit masks, unimplemented bits read as zero
    localparam logic [15:0] GROUP_SEL_MASK = 16'h0707;
    localparam logic [15:0] ZERO_SEL_MASK  = 16'h9f9f;
    // reset values
    localparam logic [15:0] GROUP_SEL_RESET = 16'h0000;
    localparam logic [15:0] ZERO_SEL_RESET  = 16'h0000;
    // mode and status register fields
    localparam int MODE_TWELVE_BIT = 0;
    localparam int MODE_LARGE_BIT  = 1;
    localparam int MODE_SAMPLE_BIT = 2;
    // highest channel zero code per variant
    localparam logic [4:0] ZERO_MAX_LARGE = 5'h08;
    localparam logic [4:0] ZERO_MAX_SMALL = 5'h05;
    // analog input numbers
    localparam logic [3:0] AN_VREF = 4'hf;  // code meaning negative reference
    localparam logic [3:0] AN_NONE = 4'he;  // code meaning no defined input
    localparam logic [3:0] AN_ONE  = 4'h1;
    localparam logic [3:0] AN_SIX  = 4'h6;
    localparam logic [3:0] AN_ZERO = 4'h0;
    localparam logic [3:0] AN_THREE = 4'h3;

    // routing of one converter channel
    typedef struct packed {
        logic [3:0] pos;  // analog input number or AN_NONE
        logic [3:0] neg;  // analog input number, AN_VREF or AN_NONE
    } acs_route_s;

    // one complete sample field set
    typedef struct packed {
        logic [4:0] zero_pos;
        logic       zero_neg;
        logic       grp_pos;
        logic [1:0] grp_neg;
    } acs_fields_s;
endpackage

/* File: src/acs_route_decode.sv */
`timescale 1ns/1ns
// decodes one field set into routes for channel 0 and channels 1 to 3
module acs_route_decode (
    // field set and configuration
    input  wire logic                 twelve_bit_mode_select_i,
    input  wire logic                 large_variant_i,
    input  wire acs_pkg::acs_fields_s fields_i,
    // decoded routes
    output acs_pkg::acs_route_s       ch0_o,
    output acs_pkg::acs_route_s       ch1_o,
    output acs_pkg::acs_route_s       ch2_o,
    output acs_pkg::acs_route_s       ch3_o
);
    logic [3:0] grp_pos_base;  // positive input of channel 1
    logic [3:0] grp_neg_base;  // negative input of channel 1
    logic       grp_neg_pins;  // grouped negatives come from inputs 6 to 8
    logic [4:0] zero_max;      // highest valid channel zero code

    // grouped and channel zero decode
    always_comb begin
        zero_max = large_variant_i ? acs_pkg::ZERO_MAX_LARGE : acs_pkg::ZERO_MAX_SMALL;
        // channel zero positive, code n is input n
        if (fields_i.zero_pos <= zero_max) begin
            ch0_o.pos = fields_i.zero_pos[3:0];
        end else begin
            ch0_o.pos = acs_pkg::AN_NONE;  // out-of-range codes connect nothing
        end
        ch0_o.neg = fields_i.zero_neg ? acs_pkg::AN_ONE : acs_pkg::AN_VREF;
        grp_pos_base = fields_i.grp_pos ? acs_pkg::AN_THREE : acs_pkg::AN_ZERO;
        grp_neg_pins = large_variant_i && (fields_i.grp_neg == 2'h2);
        grp_neg_base = grp_neg_pins ? acs_pkg::AN_SIX : acs_pkg::AN_VREF;
        if (fields_i.grp_neg[1] && !grp_neg_pins) begin
            grp_neg_base = acs_pkg::AN_NONE;  // reserved codes
        end
        if (twelve_bit_mode_select_i) begin
            // grouped channels are not defined in this mode
            ch1_o = '{pos: acs_pkg::AN_NONE, neg: acs_pkg::AN_NONE};
            ch2_o = '{pos: acs_pkg::AN_NONE, neg: acs_pkg::AN_NONE};
            ch3_o = '{pos: acs_pkg::AN_NONE, neg: acs_pkg::AN_NONE};
        end else begin
            ch1_o.pos = grp_pos_base;
            ch2_o.pos = grp_pos_base + 4'h1;
            ch3_o.pos = grp_pos_base + 4'h2;
            // reference and none are shared by all three channels
            ch1_o.neg = grp_neg_base;
            ch2_o.neg = grp_neg_pins ? grp_neg_base + 4'h1 : grp_neg_base;
            ch3_o.neg = grp_neg_pins ? grp_neg_base + 4'h2 : grp_neg_base;
        end
    end
endmodule

/* File: src/acs_input_select.sv */
// The APB register port and the address map were decided locally.
`timescale 1ns/1ns
module acs_input_select (
    // clock, reset, enable
    input  wire logic                 sys_clk_i,
    input  wire logic                 reset_i,
    input  wire logic                 clk_en_i,
    // apb slave
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [11:0]          paddr_i,
    input  wire logic [31:0]          pwdata_i,
    output logic [31:0]               prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    // converter side
    input  wire logic                 sample_b_i,
    output acs_pkg::acs_route_s       ch0_o,
    output acs_pkg::acs_route_s       ch1_o,
    output acs_pkg::acs_route_s       ch2_o,
    output acs_pkg::acs_route_s       ch3_o
);
    logic [15:0]         group_channel_input_select;  // grouped select register
    logic [15:0]         next_group_channel_input_select;
    logic [15:0]         channel_zero_input_select;   // channel zero select register
    logic [15:0]         next_channel_zero_input_select;
    logic                twelve_bit_mode_select;      // converter resolution
    logic                next_twelve_bit_mode_select;
    logic                large_variant;               // pin-count variant
    logic                next_large_variant;
    logic [31:0]         next_prdata;
    logic                next_pready;
    logic                next_pslverr;
    logic                sample_b;                    // registered alternation state
    logic                next_sample_b;
    acs_pkg::acs_fields_s fields;                     // active field set
    acs_pkg::acs_route_s r0, r1, r2, r3;              // decoded routes
    acs_pkg::acs_route_s next_ch0, next_ch1, next_ch2, next_ch3;
    logic                access;                      // access phase, answered with pready in the next cycle
    logic                hit;                         // address is mapped
    logic                done;                        // edge at which the master completes

    // apb register next values, one wait state per access phase
    always_comb begin
        next_group_channel_input_select = group_channel_input_select;
        next_channel_zero_input_select  = channel_zero_input_select;
        next_twelve_bit_mode_select     = twelve_bit_mode_select;
        next_large_variant              = large_variant;
        next_prdata  = prdata_o;
        next_pslverr = 1'b0;
        access = psel_i && penable_i && !pready_o;
        // the master completes the transfer at the edge that samples pready high
        done = psel_i && penable_i && pready_o;
        // pready pulses one cycle after the access phase starts
        next_pready = access;
        hit = (paddr_i == acs_pkg::GROUP_SEL_ADDR) || (paddr_i == acs_pkg::ZERO_SEL_ADDR) ||
              (paddr_i == acs_pkg::MODE_ADDR) || (paddr_i == acs_pkg::STATUS_ADDR);
        // writes land only at the completing edge, so a stalled access stores nothing early
        if (done && pwrite_i) begin
            unique case (paddr_i)
                acs_pkg::GROUP_SEL_ADDR: begin
                    next_group_channel_input_select = pwdata_i[15:0] &
                                                      acs_pkg::GROUP_SEL_MASK;
                end
                acs_pkg::ZERO_SEL_ADDR: begin
                    next_channel_zero_input_select = pwdata_i[15:0] &
                                                     acs_pkg::ZERO_SEL_MASK;
                end
                acs_pkg::MODE_ADDR: begin
                    next_twelve_bit_mode_select = pwdata_i[acs_pkg::MODE_TWELVE_BIT];
                    next_large_variant          = pwdata_i[acs_pkg::MODE_LARGE_BIT];
                end
                default: begin
                    // status is read only, unmapped writes are dropped
                end
            endcase
        end
        if (access) begin
            next_pslverr = !hit;  // unmapped address answers with an error
            next_prdata  = 32'h0000_0000;
            if (!pwrite_i) begin
                unique case (paddr_i)
                    acs_pkg::GROUP_SEL_ADDR: next_prdata = {16'h0000, group_channel_input_select};
                    acs_pkg::ZERO_SEL_ADDR:  next_prdata = {16'h0000, channel_zero_input_select};
                    acs_pkg::MODE_ADDR: begin
                        next_prdata[acs_pkg::MODE_TWELVE_BIT] = twelve_bit_mode_select;
                        next_prdata[acs_pkg::MODE_LARGE_BIT]  = large_variant;
                    end
                    acs_pkg::STATUS_ADDR: begin
                        // live view of which field set drives the mux
                        next_prdata[acs_pkg::MODE_SAMPLE_BIT] = sample_b;
                        next_prdata[7:4] = ch0_o.pos;
                    end
                    default: next_prdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // field set chosen by sample alternation state
    always_comb begin
        next_sample_b = sample_b_i;
        if (sample_b) begin
            fields.zero_pos = channel_zero_input_select[acs_pkg::ZERO_POS_B_LSB +: 5];
            fields.zero_neg = channel_zero_input_select[acs_pkg::ZERO_NEG_B_BIT];
            fields.grp_pos  = group_channel_input_select[acs_pkg::GRP_POS_B_BIT];
            fields.grp_neg  = group_channel_input_select[acs_pkg::GRP_NEG_B_LSB +: 2];
        end else begin
            fields.zero_pos = channel_zero_input_select[acs_pkg::ZERO_POS_A_LSB +: 5];
            fields.zero_neg = channel_zero_input_select[acs_pkg::ZERO_NEG_A_BIT];
            fields.grp_pos  = group_channel_input_select[acs_pkg::GRP_POS_A_BIT];
            fields.grp_neg  = group_channel_input_select[acs_pkg::GRP_NEG_A_LSB +: 2];
        end
        // routes are registered so outputs come straight from flops
        next_ch0 = r0;
        next_ch1 = r1;
        next_ch2 = r2;
        next_ch3 = r3;
    end

    // shared decoder for whichever field set is active
    acs_route_decode u_decode (
        .twelve_bit_mode_select_i (twelve_bit_mode_select),
        .large_variant_i          (large_variant),
        .fields_i                 (fields),
        .ch0_o                    (r0),
        .ch1_o                    (r1),
        .ch2_o                    (r2),
        .ch3_o                    (r3)
    );

    // state registers, frozen while the enable is low unless reset is high
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            group_channel_input_select <= acs_pkg::GROUP_SEL_RESET;
            channel_zero_input_select  <= acs_pkg::ZERO_SEL_RESET;
            twelve_bit_mode_select     <= 1'b0;
            large_variant              <= 1'b1;
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            sample_b  <= 1'b0;
            ch0_o <= '{pos: acs_pkg::AN_ZERO, neg: acs_pkg::AN_VREF};
            ch1_o <= '{pos: acs_pkg::AN_ZERO, neg: acs_pkg::AN_VREF};
            ch2_o <= '{pos: acs_pkg::AN_ONE,  neg: acs_pkg::AN_VREF};
            ch3_o <= '{pos: 4'h2,             neg: acs_pkg::AN_VREF};
        end else if (clk_en_i) begin
            group_channel_input_select <= next_group_channel_input_select;
            channel_zero_input_select  <= next_channel_zero_input_select;
            twelve_bit_mode_select     <= next_twelve_bit_mode_select;
            large_variant              <= next_large_variant;
            prdata_o  <= next_prdata;
            pready_o  <= next_pready;
            pslverr_o <= next_pslverr;
            sample_b  <= next_sample_b;
            ch0_o <= next_ch0;
            ch1_o <= next_ch1;
            ch2_o <= next_ch2;
            ch3_o <= next_ch3;
        end
    end
endmodule

/* File: verif/acs_input_select_monitor.sv */
`timescale 1ns/1ns
// watches the apb answer and the route outputs of the select block
module acs_monitor (
    // clock and reset
    input wire logic                 sys_clk_i,
    input wire logic                 reset_i,
    input wire logic                 clk_en_i,
    // apb
    input wire logic                 psel_i,
    input wire logic                 penable_i,
    input wire logic [11:0]          paddr_i,
    input wire logic [31:0]          prdata_o,
    input wire logic                 pready_o,
    input wire logic                 pslverr_o,
    // converter side
    input wire logic                 sample_b_i,
    input wire acs_pkg::acs_route_s  ch0_o,
    input wire acs_pkg::acs_route_s  ch1_o,
    input wire acs_pkg::acs_route_s  ch2_o,
    input wire acs_pkg::acs_route_s  ch3_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    // an access phase that the slave has not yet answered
    sequence s_take;
        psel_i && penable_i && !pready_o && clk_en_i;
    endsequence
    // no bus traffic, running clock and a steady sample state: routes have nothing to follow
    sequence s_quiet;
        (!psel_i && clk_en_i && $stable(sample_b_i)) [*4];
    endsequence
    AST_APB_ANSWER: assert property (s_take |=> pready_o)
        else $error("apb access not answered in one wait state");
    AST_APB_PULSE: assert property (pready_o && clk_en_i |=> !pready_o)
        else $error("pready stood more than one cycle");
    AST_ERR_UNMAPPED: assert property (pready_o && pslverr_o |->
        !(paddr_i inside {12'h000, 12'h004, 12'h008, 12'h00c}) && prdata_o == 32'h0)
        else $error("error answer on a mapped address");
    AST_ERR_MAPPED: assert property (pready_o && (paddr_i inside {12'h000, 12'h004}) |-> !pslverr_o)
        else $error("select register access refused");
    AST_ZERO_NEG: assert property (ch0_o.neg == 4'h1 || ch0_o.neg == 4'hf)
        else $error("channel 0 negative route illegal");
    AST_ZERO_POS: assert property (ch0_o.pos <= 4'h8 || ch0_o.pos == 4'he)
        else $error("channel 0 positive route illegal");
    AST_GRP_POS: assert property (ch1_o.pos != 4'he |-> (ch1_o.pos inside {4'h0, 4'h3})
        && ch2_o.pos == ch1_o.pos + 4'h1 && ch3_o.pos == ch1_o.pos + 4'h2)
        else $error("grouped positive routes inconsistent");
    AST_GRP_NEG: assert property ((ch1_o.neg inside {4'h6, 4'he, 4'hf}) &&
        ((ch1_o.neg == 4'h6) ? (ch2_o.neg == 4'h7 && ch3_o.neg == 4'h8) :
         (ch2_o.neg == ch1_o.neg && ch3_o.neg == ch1_o.neg)))
        else $error("grouped negative routes inconsistent");
    AST_TWELVE: assert property (ch1_o.pos == 4'he |-> ch1_o.neg == 4'he
        && ch2_o == 8'hee && ch3_o == 8'hee)
        else $error("twelve-bit mode left a grouped route defined");
    AST_ROUTE_HOLD: assert property (s_quiet |-> $stable(ch0_o) && $stable(ch1_o))
        else $error("routes moved with no cause");
endmodule

bind acs_input_select acs_monitor mon_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .clk_en_i(clk_en_i), .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .sample_b_i(sample_b_i),
    .ch0_o(ch0_o), .ch1_o(ch1_o), .ch2_o(ch2_o), .ch3_o(ch3_o));

/* File: verif/acs_input_select_tb_top.sv */
`timescale 1ns/1ns
module acs_input_select_tb_top;
    logic                sys_clk_i, reset_i, clk_en_i, psel, penable, pwrite, sample_b;
    logic [11:0]         paddr;
    logic [31:0]         pwdata, prdata, rd;
    logic                pready, pslverr, err, tw, lg, sb;
    logic [15:0]         g, z;
    acs_pkg::acs_route_s ch [4];
    acs_pkg::acs_route_s e0;   // expected channel zero route for status reads
    int                  n_mismatch, checked, seed;
    acs_input_select dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .sample_b_i(sample_b), .ch0_o(ch[0]), .ch1_o(ch[1]), .ch2_o(ch[2]), .ch3_o(ch[3]));
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    task automatic finish_test;
        if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; pready is sampled at the rising edge, the request released after it
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // released bus shows the inverted data instead of d
    endtask
    // expected route of one channel for the selected field set
    function automatic acs_pkg::acs_route_s exp_ch(int c, logic t, logic l, logic b,
                                                   logic [15:0] gr, logic [15:0] zr);
        acs_pkg::acs_route_s r;
        logic [4:0] zp = b ? zr[12:8] : zr[4:0];
        logic [1:0] gn = b ? gr[10:9] : gr[2:1];
        if (c == 0) begin
            r.pos = (zp <= (l ? 5'h08 : 5'h05)) ? zp[3:0] : 4'he;
            r.neg = (b ? zr[15] : zr[7]) ? 4'h1 : 4'hf;
        end else if (t) r = 8'hee;
        else begin
            r.pos = (b ? gr[8] : gr[0]) ? 4'(c + 2) : 4'(c - 1);
            r.neg = (gn == 2'b10 && l) ? 4'(c + 5) : (gn[1] ? 4'he : 4'hf);
        end
        return r;
    endfunction
    task automatic chk_routes;
        repeat (4) @(posedge sys_clk_i);
        #1;
        for (int k = 0; k < 4; k++) chk(32'(ch[k]), 32'(exp_ch(k, tw, lg, sb, g, z)));
    endtask
    initial begin
        #200000;
        n_mismatch++;
        finish_test();
    end
    initial begin
        seed = $urandom(89873);
        reset_i = 1'b1; clk_en_i = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; sample_b = 1'b0;
        n_mismatch = 0; checked = 0;
        tw = 1'b0; lg = 1'b1; sb = 1'b0; g = 16'h0; z = 16'h0;
        repeat (8) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        chk_routes();
        apb(1'b0, acs_pkg::GROUP_SEL_ADDR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, acs_pkg::ZERO_SEL_ADDR, 32'h0);
        chk(rd, 32'h0);
        // unmapped write then read: refused, nothing stored
        apb(1'b1, 12'h010, 32'hffff_ffff);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        // every channel zero code on both variants, other fields at random
        for (int i = 0; i < 64; i++) begin
            lg = i[5]; tw = ($urandom_range(3) == 0); sb = 1'($urandom);
            g = 16'($urandom); z = 16'($urandom);
            z[4:0] = 5'(i); z[12:8] = 5'(i + 7);
            apb(1'b1, acs_pkg::MODE_ADDR, {30'h0, lg, tw});
            apb(1'b1, acs_pkg::GROUP_SEL_ADDR, {16'($urandom), g});
            apb(1'b1, acs_pkg::ZERO_SEL_ADDR, {16'($urandom), z});
            sample_b <= sb;
            apb(1'b0, acs_pkg::GROUP_SEL_ADDR, 32'h0);
            chk(rd, {16'h0, g & acs_pkg::GROUP_SEL_MASK});
            apb(1'b0, acs_pkg::ZERO_SEL_ADDR, 32'h0);
            chk(rd, {16'h0, z & acs_pkg::ZERO_SEL_MASK});
            // status is read only: a write is accepted without error and changes nothing
            apb(1'b1, acs_pkg::STATUS_ADDR, 32'hffff_ffff);
            chk({31'h0, err}, 32'h0);
            apb(1'b0, acs_pkg::MODE_ADDR, 32'h0);
            chk(rd, {30'h0, lg, tw});
            e0 = exp_ch(0, tw, lg, sb, g, z);
            apb(1'b0, acs_pkg::STATUS_ADDR, 32'h0);
            chk(rd, {24'h0, e0.pos, 1'b0, sb, 2'h0});
            chk_routes();
        end
        // enable low freezes the routes although the sample state flips
        @(posedge sys_clk_i);
        clk_en_i <= 1'b0;
        sample_b <= ~sb;
        repeat (6) @(posedge sys_clk_i);
        #1;
        for (int k = 0; k < 4; k++) chk(32'(ch[k]), 32'(exp_ch(k, tw, lg, sb, g, z)));
        @(posedge sys_clk_i);
        clk_en_i <= 1'b1;
        sb = ~sb;
        chk_routes();
        // reset in mid-run returns every register to its reset value
        @(posedge sys_clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        tw = 1'b0;
        lg = 1'b1;
        g = 16'h0;
        z = 16'h0;
        chk_routes();
        apb(1'b0, acs_pkg::MODE_ADDR, 32'h0);
        chk(rd, 32'h2);
        apb(1'b0, acs_pkg::ZERO_SEL_ADDR, 32'h0);
        chk(rd, 32'h0);
        finish_test();
    end
endmodule
